// [epvs_params.svh]
// Constants for the memory programmer controller
`ifndef EPVS_PARAMS_SVH
`define EPVS_PARAMS_SVH
`define EPVS_CLK_HZ 10000000
`define EPVS_PULSE_US 100
`define EPVS_MAX_PULSES 10
`define EPVS_SETTLE_CYC 2
`define EPVS_READ_CYC 3
`define EPVS_ADDR_W 17
`define EPVS_DATA_W 8
`define EPVS_ERASED 8'hFF
`endif

// [epvs_pkg.sv]
// Types for the memory programmer controller
`default_nettype none
`include "epvs_params.svh"
package epvs_pkg;
  typedef enum logic [2:0]
  {
    EPVS_IDLE = 3'b000,
    EPVS_SETUP = 3'b001,
    EPVS_PULSE = 3'b011,
    EPVS_VERIFY = 3'b010,
    EPVS_CHECK = 3'b110,
    EPVS_DONE = 3'b111,
    EPVS_READ = 3'b101
  } epvs_state_t;
  typedef enum logic [1:0]
  {
    EPVS_OP_PROG = 2'h0,
    EPVS_OP_READ = 2'h1,
    EPVS_OP_SIG = 2'h2,
    EPVS_OP_FINAL = 2'h3
  } epvs_op_t;
endpackage
`default_nettype wire

// [epvs_tmr_if.sv]
// Interface between controller and pulse timer
`timescale 1ns/100ps
`default_nettype none
interface epvs_tmr_if;
  logic start;
  logic [15:0] count;
  logic done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface
`default_nettype wire

// [epvs_timer.sv]
// Cycle counter used for pulse widths and settle times
`timescale 1ns/100ps
`default_nettype none
module epvs_timer
(
  input wire logic clk_sys,
  input wire logic reset_n,
  epvs_tmr_if.tmr tif
);
  logic [15:0] left;
  logic busy;
  // Count down from the loaded value; done pulses when the count reaches one
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      left <= 16'h0000;
      busy <= 1'b0;
      tif.done <= 1'b0;
    end
    else
    begin
      tif.done <= 1'b0;
      if (tif.start)
      begin
        left <= tif.count;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (left <= 16'h0001)
        begin
          busy <= 1'b0;
          tif.done <= 1'b1;
        end
        else
          left <= left - 16'h0001;
      end
    end
  end
endmodule // epvs_timer
`default_nettype wire

// [epvs_sync.sv]
// Two-flop synchroniser for the data pins
`timescale 1ns/100ps
`default_nettype none
module epvs_sync
#(
  parameter int W = 8
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (W < 1)
  begin : g_bad_width
    $error("epvs_sync: width must be positive");
  end
  logic [W-1:0] meta;
  // First stage is read only by the second
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta <= '1;
      dout <= '1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // epvs_sync
`default_nettype wire

// [epvs_ctrl.sv]
// Programmer controller: pulse-verify loop, reads, signature and final check
`timescale 1ns/100ps
`default_nettype none
`include "epvs_params.svh"
module epvs_ctrl
#(
  parameter int ADDR_W = `EPVS_ADDR_W,
  parameter int PULSE_CYC = (`EPVS_PULSE_US * (`EPVS_CLK_HZ / 1000000))
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire epvs_pkg::epvs_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_fail,
  output logic [ADDR_W-1:0] fail_addr,
  output logic [3:0] rsp_pulses,
  output logic [ADDR_W-1:0] addr_pins,
  output logic addr_bit_nine_high_v,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [7:0] data_pins_i,
  output logic chip_on_n,
  output logic out_drv_n,
  output logic burn_strobe_n,
  output logic prog_supply_on
);
  import epvs_pkg::*;
  // Pulse timer is loaded one short, so two cycles is the shortest strobe
  if (ADDR_W < 10 || PULSE_CYC < 2 || PULSE_CYC > 65535)
  begin : g_bad_params
    $error("epvs_ctrl: unsupported parameters");
  end
  localparam logic [15:0] PULSE_CNT = 16'(PULSE_CYC);
  localparam logic [3:0] MAX_PULSES = 4'(`EPVS_MAX_PULSES);
  epvs_state_t state;
  epvs_op_t op;
  logic [7:0] want;
  logic [7:0] rd_data;
  logic [3:0] pulses;
  logic started;
  epvs_tmr_if tif ();
  epvs_timer u_timer
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tif(tif)
  );
  epvs_sync #(.W(8)) u_sync
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(data_pins_i),
    .dout(rd_data)
  );
  // Compare helper; also used in the final pass
  function automatic logic epvs_match(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction
  // Start the timer on state entry only
  always_comb
  begin
    tif.start = 1'b0;
    tif.count = 16'(`EPVS_SETTLE_CYC);
    if (!started)
    begin
      tif.start = (state == EPVS_SETUP) || (state == EPVS_PULSE) ||
        (state == EPVS_VERIFY) || (state == EPVS_READ);
      // Done lands a cycle after the count runs out, hence one short
      if (state == EPVS_PULSE)
        tif.count = PULSE_CNT - 16'h0001;
      else if (state == EPVS_VERIFY || state == EPVS_READ)
        tif.count = 16'(`EPVS_READ_CYC);
    end
  end
  // Sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state <= EPVS_IDLE;
      op <= EPVS_OP_PROG;
      want <= `EPVS_ERASED;
      pulses <= 4'h0;
      started <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
      unique case (state)
        EPVS_IDLE:
        begin
          if (cmd_valid)
          begin
            op <= cmd_op;
            want <= cmd_data;
            pulses <= 4'h0;
            started <= 1'b0;
            // Any address order is accepted from the host
            state <= (cmd_op == EPVS_OP_PROG) ? EPVS_SETUP : EPVS_READ;
          end
        end
        EPVS_SETUP:
        begin
          if (started && tif.done)
          begin
            started <= 1'b0;
            state <= EPVS_PULSE;
          end
        end
        EPVS_PULSE:
        begin
          if (started && tif.done)
          begin
            pulses <= pulses + 4'h1;
            started <= 1'b0;
            state <= EPVS_VERIFY;
          end
        end
        EPVS_VERIFY:
        begin
          if (started && tif.done)
            state <= EPVS_CHECK;
        end
        EPVS_CHECK:
        begin
          started <= 1'b0;
          if (epvs_match(rd_data, want) || pulses >= MAX_PULSES)
            state <= EPVS_DONE;
          else
            state <= EPVS_SETUP;
        end
        EPVS_READ:
        begin
          if (started && tif.done)
            state <= EPVS_DONE;
        end
        EPVS_DONE:
          state <= EPVS_IDLE;
        default:
          state <= EPVS_IDLE;
      endcase
    end
  end
  // Pin drive; every pin registered, identical for parallel devices
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      addr_pins <= '0;
      addr_bit_nine_high_v <= 1'b0;
      data_pins_o <= 8'h00;
      data_pins_oe <= 1'b0;
      chip_on_n <= 1'b1;
      out_drv_n <= 1'b1;
      burn_strobe_n <= 1'b1;
      prog_supply_on <= 1'b0;
    end
    else
    begin
      burn_strobe_n <= 1'b1;
      if (state == EPVS_IDLE)
      begin
        chip_on_n <= 1'b1; // Standby between commands
        out_drv_n <= 1'b1;
        data_pins_oe <= 1'b0;
        addr_bit_nine_high_v <= 1'b0;
        prog_supply_on <= 1'b0;
        if (cmd_valid)
        begin
          addr_pins <= cmd_addr;
          data_pins_o <= cmd_data;
          if (cmd_op == EPVS_OP_SIG)
          begin
            addr_pins <= '0;
            addr_pins[0] <= cmd_addr[0];
            addr_bit_nine_high_v <= 1'b1;
          end
        end
      end
      else if (op == EPVS_OP_PROG)
      begin
        prog_supply_on <= 1'b1;
        chip_on_n <= 1'b0;
        if (state == EPVS_SETUP || state == EPVS_PULSE)
        begin
          out_drv_n <= 1'b1;
          data_pins_oe <= 1'b1;
          // Strobe only after settle time has elapsed
          burn_strobe_n <= !(state == EPVS_PULSE && !(started && tif.done));
        end
        else
        begin
          data_pins_oe <= 1'b0;
          out_drv_n <= 1'b0;
        end
      end
      else
      begin
        // Reads, signature and final pass all at read supply
        prog_supply_on <= 1'b0;
        chip_on_n <= 1'b0;
        out_drv_n <= 1'b0;
        data_pins_oe <= 1'b0;
      end
    end
  end
  // Answer to host
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_fail <= 1'b0;
      fail_addr <= '0;
      rsp_pulses <= 4'h0;
    end
    else
    begin
      cmd_ready <= (state == EPVS_IDLE) && !cmd_valid;
      rsp_valid <= 1'b0;
      if (state == EPVS_CHECK && (epvs_match(rd_data, want) || pulses >= MAX_PULSES))
      begin
        rsp_valid <= 1'b1;
        rsp_data <= rd_data;
        rsp_pulses <= pulses;
        rsp_fail <= !epvs_match(rd_data, want);
        if (!epvs_match(rd_data, want))
          fail_addr <= addr_pins;
      end
      else if (state == EPVS_READ && started && tif.done)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= rd_data;
        rsp_pulses <= 4'h0;
        rsp_fail <= (op == EPVS_OP_FINAL) && !epvs_match(rd_data, want);
        if ((op == EPVS_OP_FINAL) && !epvs_match(rd_data, want))
          fail_addr <= addr_pins;
      end
    end
  end
  // Strobe width counter for checking
  logic [15:0] low_cnt;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      low_cnt <= 16'h0000;
    else if (!burn_strobe_n)
      low_cnt <= low_cnt + 16'h0001;
    else
      low_cnt <= 16'h0000;
  end
  strobe_width_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !burn_strobe_n |-> (low_cnt < PULSE_CNT))
    else $error("strobe low too long");
  strobe_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($rose(burn_strobe_n) && state != EPVS_IDLE) |-> ($past(low_cnt) == PULSE_CNT - 16'h0001))
    else $error("strobe width wrong");
  pulse_limit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pulses <= MAX_PULSES)
    else $error("too many pulses");
  strobe_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !burn_strobe_n |-> (!chip_on_n && out_drv_n && prog_supply_on && data_pins_oe))
    else $error("strobe outside program mode");
  data_stable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(burn_strobe_n) |-> ($stable(addr_pins) && $stable(data_pins_o) && $past(data_pins_oe)))
    else $error("strobe before settle");
  verify_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(burn_strobe_n) |=> (!out_drv_n && !data_pins_oe && prog_supply_on))
    else $error("verify setup wrong");
  sig_lines_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    addr_bit_nine_high_v |-> (addr_pins[ADDR_W-1:1] == '0 && !prog_supply_on))
    else $error("signature address wrong");
  fail_report_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rsp_valid && rsp_fail && op == EPVS_OP_PROG) |-> (rsp_pulses == MAX_PULSES))
    else $error("early failure");
  no_contend_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    data_pins_oe |-> out_drv_n)
    else $error("bus contention");
  prog_cover_c: cover property (@(posedge clk_sys) rsp_valid && !rsp_fail && rsp_pulses == 4'h1);
  fail_cover_c: cover property (@(posedge clk_sys) rsp_valid && rsp_fail);
  sig_cover_c: cover property (@(posedge clk_sys) addr_bit_nine_high_v && rsp_valid);
endmodule // epvs_ctrl
`default_nettype wire

// [epvs_mem_model.sv]
// Behavioural model of the byte-wide programmable memory
`timescale 1ns/100ps
`default_nettype none
module epvs_mem_model
#(
  parameter int PULSE_NS = 1000,
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h5A // Arbitrary value
)
(
  input wire logic [16:0] addr_pins, // Shared pins only
  input wire logic addr_bit_nine_high_v,
  input wire logic chip_on_n,
  input wire logic out_drv_n,
  input wire logic burn_strobe_n,
  input wire logic prog_supply_on,
  input wire logic data_pins_oe,
  input wire logic [7:0] data_pins_i,
  input wire logic [3:0] need,
  output logic [7:0] dev_q,
  output int dev_faults
);
  logic [7:0] mem [int];
  logic [7:0] v;
  logic [7:0] hold = 8'h00;
  logic drv;
  int gen = 0;
  int cnt = 0;
  realtime t_fall = 0;
  realtime t_chg = 0;
  initial dev_faults = 0;
  // Outputs on only with chip and outputs enabled, strobe high
  assign drv = !chip_on_n && !out_drv_n && burn_strobe_n;
  // Stored byte or identifier; erased places read ones
  always @(addr_pins or addr_bit_nine_high_v or gen)
    if (addr_bit_nine_high_v) v = addr_pins[0] ? TYPE_ID : MAKER_ID;
    else v = mem.exists(int'(addr_pins)) ? mem[int'(addr_pins)] : 8'hFF;
  // Released lines show the inverse, so stale data never passes
  always @(drv or v or hold)
    dev_q = drv ? v : ~hold;
  always @(drv or v)
    if (drv) hold = v;
  // Setup hazard: strobe must not fall with pins still moving
  always @(addr_pins or data_pins_i) t_chg = $realtime;
  always @(negedge burn_strobe_n)
  begin
    t_fall = $realtime;
    if (t_chg == $realtime || !data_pins_oe) dev_faults++;
  end
  // Bits change only with chip on, outputs off, high supply
  always @(posedge burn_strobe_n)
    if (!chip_on_n && out_drv_n && prog_supply_on)
    begin
      cnt++;
      if ($realtime - t_fall != PULSE_NS || cnt > 10) dev_faults++;
      if (cnt >= need)
      begin
        mem[int'(addr_pins)] = v & data_pins_i;
        gen++;
      end
    end
  always @(posedge chip_on_n) cnt = 0;
  // Identifier reads: other address lines low, read supply
  always @(negedge out_drv_n)
    #1 if (addr_bit_nine_high_v && ((addr_pins & 17'h1FDFE) != 0 || prog_supply_on))
      dev_faults++;
  always @(drv or data_pins_oe)
    #1 if (drv && data_pins_oe) dev_faults++;
endmodule // epvs_mem_model
`default_nettype wire

// [epvs_ctrl_tb_top.sv]
// Testbench for the memory programmer controller
`timescale 1ns/100ps
`default_nettype none
module epvs_ctrl_tb_top;
  import epvs_pkg::*;
  localparam int PULSE_CYC = 10;
  localparam logic [7:0] MK = 8'h3C; // Arbitrary value
  localparam logic [7:0] TY = 8'h5A; // Arbitrary value
  logic clk_sys, reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_fail;
  logic addr_bit_nine_high_v, data_pins_oe, chip_on_n, out_drv_n, burn_strobe_n, prog_supply_on;
  epvs_op_t cmd_op;
  logic [16:0] cmd_addr, fail_addr, addr_pins;
  logic [7:0] cmd_data, rsp_data, data_pins_o, data_pins_i, dev_q;
  logic [3:0] rsp_pulses, need;
  int dev_faults;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 45;
  int cycles = 0;
  int ref_mem [int];
  int done_q [$];
  assign data_pins_i = data_pins_oe ? data_pins_o : dev_q;
  epvs_ctrl #(.ADDR_W(17), .PULSE_CYC(PULSE_CYC)) uut
  (
    .clk_sys, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_fail, .fail_addr, .rsp_pulses, .addr_pins,
    .addr_bit_nine_high_v, .data_pins_o, .data_pins_oe, .data_pins_i,
    .chip_on_n, .out_drv_n, .burn_strobe_n, .prog_supply_on
  );
  epvs_mem_model #(.PULSE_NS(PULSE_CYC * 100), .MAKER_ID(MK), .TYPE_ID(TY)) dev
  (
    .addr_pins, .addr_bit_nine_high_v, .chip_on_n, .out_drv_n, .burn_strobe_n,
    .prog_supply_on, .data_pins_oe, .data_pins_i, .need, .dev_q, .dev_faults
  );
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Shared comparison
  task automatic check(input string nm, input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One command: wait ready, one-cycle valid, wait answer
  task automatic run(input epvs_op_t op, input int a, input int d);
    int k;
    @(negedge clk_sys);
    for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
    cmd_op = op;
    cmd_addr = a[16:0];
    cmd_data = d[7:0];
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (k = 0; k < 600 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
    check("rsp_valid", 17'd1, 17'(rsp_valid));
  endtask
  function automatic logic [16:0] stored(input int a);
    return 17'(ref_mem.exists(a) ? ref_mem[a] : 255);
  endfunction
  // Program with model needing n pulses; bits only clear
  task automatic prog(input int a, input int d, input int n);
    int e;
    int ok;
    e = stored(a);
    need = n[3:0];
    run(EPVS_OP_PROG, a, d);
    if (n <= 10) ref_mem[a] = e & d;
    ok = (n <= 10) && ((e & d) == d);
    check("rsp_fail", 17'(!ok), 17'(rsp_fail));
    check("prog data", stored(a), 17'(rsp_data));
    check("rsp_pulses", ok ? 17'(n) : 17'd10, 17'(rsp_pulses));
    if (!ok) check("fail_addr", a[16:0], fail_addr);
  endtask
  task automatic fin(input int a, input int d);
    run(EPVS_OP_FINAL, a, d);
    check("final fail", 17'(stored(a) != 17'(d)), 17'(rsp_fail));
  endtask
  // Main sequence
  initial
  begin
    int a, d, n, i;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = EPVS_OP_READ;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    need = 4'h1;
    repeat (10) @(negedge clk_sys);
    check("chip_on_n", 17'd1, 17'(chip_on_n));
    check("burn_strobe_n", 17'd1, 17'(burn_strobe_n));
    check("cmd_ready", 17'd0, 17'(cmd_ready));
    reset_n = 1'b1;
    run(EPVS_OP_READ, 'h1ABCD, 0);
    check("erased", stored('h1ABCD), 17'(rsp_data));
    // Descending addresses, random bytes and pulse needs
    for (i = 0; i < 6; i++)
    begin
      a = 'h1F000 - i * 'h111;
      d = $random(seed) & 'hFF;
      n = 1 + (($random(seed) & 'h7FFFFFFF) % 10);
      prog(a, d, n);
      done_q.push_back(a);
    end
    prog(done_q[0], 'hFF, 3);
    prog('h00123, 'h5A, 11);
    foreach (done_q[j])
    begin
      run(EPVS_OP_READ, done_q[j], 0);
      check("read", stored(done_q[j]), 17'(rsp_data));
      fin(done_q[j], int'(stored(done_q[j])));
    end
    fin(done_q[1], int'(stored(done_q[1])) ^ 1);
    run(EPVS_OP_SIG, 0, 0);
    check("maker id", 17'(MK), 17'(rsp_data));
    run(EPVS_OP_SIG, 1, 0);
    check("type id", 17'(TY), 17'(rsp_data));
    check("device faults", 17'd0, 17'(dev_faults));
    give_verdict;
  end
  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict;
    end
  end
endmodule // epvs_ctrl_tb_top
`default_nettype wire
